// [hw/blt_pkg.sv]
// Purpose: Constants for the fan motor lock protection and tach block
// Assumes: 100 MHz system clock
// Notes:   Times are in milliseconds; cycle counts derive from them
package blt_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned RUN_LOCK_MS     = 300;
  localparam int unsigned START_LOCK_MS   = 700;
  localparam int unsigned RESTART_ON_MS   = 700;
  localparam int unsigned SHORT_RATIO     = 5;
  localparam int unsigned LONG_RATIO      = 20;
  localparam int unsigned SHORT_OFF_COUNT = 4;
  localparam int unsigned PWM_HZ          = 48_000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  localparam int unsigned PWM_PERIOD      = CLK_HZ / PWM_HZ;
  localparam int unsigned RUN_LOCK_CYC    = RUN_LOCK_MS * MS_CYCLES;
  localparam int unsigned START_LOCK_CYC  = START_LOCK_MS * MS_CYCLES;
  localparam int unsigned RESTART_ON_CYC  = RESTART_ON_MS * MS_CYCLES;
  localparam int unsigned TMR_W           = 32;
  localparam int unsigned DUTY_W          = 11;
  localparam int unsigned GAIN_NORMAL_SH  = 2;
  localparam int unsigned GAIN_LOW_SH     = 4;
  localparam logic [1:0]  ATT_MAX         = 2'h3;
endpackage : blt_pkg

// [hw/blt_pwm_gen.sv]
// Purpose: Fixed carrier PWM generator
// Assumes: Period set by package constant
// Notes:   Output high while counter below duty
`timescale 1ns/100ps
module blt_pwm_gen
  import blt_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Control
  input  wire logic [DUTY_W-1:0] duty,
  // Output
  output logic                   pwmOn
);
  // Carrier count needs more bits than the duty word
  localparam int unsigned CNT_W = $clog2(PWM_PERIOD);
  logic [CNT_W-1:0]  cnt_r;
  wire               wrap = (cnt_r == CNT_W'(PWM_PERIOD - 1));

  // [RULE5] carrier counter
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= '0;
      pwmOn <= 1'b0;
    end
    else
    begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      pwmOn <= (cnt_r < CNT_W'(duty));
    end
  end

  // [RULE5] counter stays in period
  property p_period;
    @(posedge sys_clk) disable iff (!nrst) cnt_r <= CNT_W'(PWM_PERIOD - 1);
  endproperty
  a_period : assert property (p_period) else $error("pwm counter over period"); // [RULE5]
endmodule : blt_pwm_gen

// [hw/blt_lock_ctrl.sv]
// Purpose: Lock detection, auto restart, gate drive and rotation output
// Assumes: Hall and current comparator levels arrive asynchronously
// Notes:   Timers shorten via parameters for simulation
// Operation
// [RULE1] While running, a Hall period longer than the running lock time declares lock.
// [RULE2] At start-up, no Hall edge within the start-up lock time declares lock.
// [RULE3] The first four off intervals last five restart on periods, followed by an on attempt.
// [RULE4] From the fifth off interval the off time is twenty on periods, using an attempt counter.
// [RULE5] Gate outputs switch at a 48 kHz carrier from the system clock; the code switches only the high sides, the low sides follow Hall.
// [RULE6] The current comparator above the 0.10 V threshold activates the limiter.
// [RULE7] An active limiter puts the bridge into regeneration instead of drive.
// [RULE8] The tach variant outputs a pulse toggling with each Hall commutation.
// [RULE9] The lock variant outputs the lock detection state on the open-drain pin; the code enables the pin in every state but ST_RUN, so also in ST_START.
// [RULE10] Two loop gains are selectable; low gain slews duty slower.
// [RULE11] Rotation during a restart on period returns to drive and clears the attempt count.
`timescale 1ns/100ps
module blt_lock_ctrl
  import blt_pkg::*;
#(
  parameter int unsigned RUN_LOCK  = RUN_LOCK_CYC,
  parameter int unsigned STRT_LOCK = START_LOCK_CYC,
  parameter int unsigned ON_TIME   = RESTART_ON_CYC,
  parameter bit          LOCK_OUT  = 1'b0,
  parameter bit          LOW_GAIN  = 1'b0
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Sensors
  input  wire logic              hallIn,
  input  wire logic              ocCompIn,
  // Speed demand
  input  wire logic [DUTY_W-1:0] dutyTarget,
  // Gate drive
  output logic                   gateHighA,
  output logic                   gateLowA,
  output logic                   gateHighB,
  output logic                   gateLowB,
  // Rotation output, open drain
  output logic                   rotOut,
  output logic                   rotOe,
  // Status
  output logic                   lockActive
);
  typedef enum logic [3:0] {
    ST_START = 4'h1,
    ST_RUN   = 4'h2,
    ST_OFF   = 4'h4,
    ST_RETRY = 4'h8
  } blt_state_t;

  blt_state_t        state_r, state_nxt;
  logic [1:0]        hallSync_r, ocSync_r;
  logic              hallPrev_r, tach_r, overCurrent_r;
  logic [TMR_W-1:0]  tmr_r;
  logic [2:0]        attempts_r;
  logic [DUTY_W-1:0] duty_r;
  logic              pwmOn;

  // Smallest gap that still moves duty by a step
  localparam int unsigned SLEW_MIN = 1 << (LOW_GAIN ? GAIN_LOW_SH : GAIN_NORMAL_SH);

  wire hallS     = hallSync_r[1];
  wire hallEdge  = hallS ^ hallPrev_r;
  wire longOff   = attempts_r >= 3'(SHORT_OFF_COUNT);
  wire [TMR_W-1:0] offLimit = TMR_W'(ON_TIME * (longOff ? LONG_RATIO : SHORT_RATIO));
  wire runTo     = (state_r == ST_RUN) && (tmr_r >= TMR_W'(RUN_LOCK));
  wire startTo   = (state_r == ST_START) && (tmr_r >= TMR_W'(STRT_LOCK));
  wire offDone   = (state_r == ST_OFF) && (tmr_r >= offLimit - 1'b1);
  wire retryTo   = (state_r == ST_RETRY) && (tmr_r >= TMR_W'(ON_TIME));
  wire driving   = (state_r == ST_START) || (state_r == ST_RUN) || (state_r == ST_RETRY);
  wire [DUTY_W-1:0] gainSh = DUTY_W'(LOW_GAIN ? GAIN_LOW_SH : GAIN_NORMAL_SH);
  wire [DUTY_W-1:0] step   = (dutyTarget > duty_r) ? ((dutyTarget - duty_r) >> gainSh) : '0;
  wire [DUTY_W-1:0] stepDn = (duty_r > dutyTarget) ? ((duty_r - dutyTarget) >> gainSh) : '0;
  wire timerClr  = hallEdge || (state_r != state_nxt);

  // Lock state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_START: if (hallEdge) state_nxt = ST_RUN;
                else if (startTo) state_nxt = ST_OFF;
      ST_RUN:   if (runTo) state_nxt = ST_OFF;
      ST_OFF:   if (offDone) state_nxt = ST_RETRY;
      ST_RETRY: if (hallEdge) state_nxt = ST_RUN;
                else if (retryTo) state_nxt = ST_OFF;
      default:  state_nxt = ST_START;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hallSync_r    <= '0;
      ocSync_r      <= '0;
      hallPrev_r    <= 1'b0;
      overCurrent_r <= 1'b0;
      state_r       <= ST_START;
      tmr_r         <= '0;
    end
    else
    begin
      hallSync_r    <= {hallSync_r[0], hallIn};
      ocSync_r      <= {ocSync_r[0], ocCompIn};
      hallPrev_r    <= hallS;
      // [RULE6] limiter from comparator
      overCurrent_r <= ocSync_r[1];
      // [RULE1] [RULE2] period timers
      state_r       <= state_nxt;
      tmr_r         <= timerClr ? '0 : tmr_r + 1'b1;
    end
  end

  // [RULE3] [RULE4] [RULE11] attempt counter
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      attempts_r <= '0;
    else if (state_r == ST_RETRY && hallEdge)
      attempts_r <= '0;
    else if (offDone && !longOff)
      attempts_r <= attempts_r + 1'b1;
  end

  // [RULE10] gain dependent duty slew
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      duty_r <= '0;
    else if (step != '0)
      duty_r <= duty_r + step;
    else if (stepDn != '0)
      duty_r <= duty_r - stepDn;
    else
      duty_r <= dutyTarget;
  end

  blt_pwm_gen u_pwm (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .duty    (duty_r),
    .pwmOn   (pwmOn)
  );

  // [RULE7] regeneration: both low sides on
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gateHighA <= 1'b0;
      gateLowA  <= 1'b0;
      gateHighB <= 1'b0;
      gateLowB  <= 1'b0;
    end
    else if (!driving)
    begin
      gateHighA <= 1'b0;
      gateLowA  <= 1'b0;
      gateHighB <= 1'b0;
      gateLowB  <= 1'b0;
    end
    else if (overCurrent_r)
    begin
      gateHighA <= 1'b0;
      gateLowA  <= 1'b1;
      gateHighB <= 1'b0;
      gateLowB  <= 1'b1;
    end
    else
    begin
      // [RULE5] phase commutation with pwm
      gateHighA <= hallS && pwmOn;
      gateLowA  <= !hallS;
      gateHighB <= !hallS && pwmOn;
      gateLowB  <= hallS;
    end
  end

  // [RULE8] [RULE9] rotation output
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tach_r     <= 1'b0;
      rotOut     <= 1'b0;
      rotOe      <= 1'b0;
      lockActive <= 1'b0;
    end
    else
    begin
      if (hallEdge)
        tach_r <= !tach_r;
      rotOut     <= 1'b0;
      rotOe      <= LOCK_OUT ? (state_nxt == ST_RUN ? 1'b0 : 1'b1) : !tach_r;
      lockActive <= (state_nxt == ST_OFF) || (state_nxt == ST_RETRY);
    end
  end

  property p_run_lock;
    @(posedge sys_clk) disable iff (!nrst) runTo |=> state_r == ST_OFF;
  endproperty
  a_run_lock : assert property (p_run_lock) else $error("run lock missed"); // [RULE1]

  property p_start_lock;
    @(posedge sys_clk) disable iff (!nrst) (startTo && !hallEdge) |=> state_r == ST_OFF;
  endproperty
  a_start_lock : assert property (p_start_lock) else $error("start lock missed"); // [RULE2]

  property p_short_off;
    @(posedge sys_clk) disable iff (!nrst)
      (state_r == ST_OFF && !longOff) |-> tmr_r < TMR_W'(ON_TIME * SHORT_RATIO);
  endproperty
  a_short_off : assert property (p_short_off) else $error("short off overran"); // [RULE3]

  property p_long_off;
    @(posedge sys_clk) disable iff (!nrst)
      (state_r == ST_OFF && attempts_r == 3'(SHORT_OFF_COUNT) && !hallEdge
       && tmr_r == TMR_W'(ON_TIME * SHORT_RATIO - 1)) |=> state_r == ST_OFF;
  endproperty
  a_long_off : assert property (p_long_off) else $error("long off not used"); // [RULE4]

  property p_off_quiet;
    @(posedge sys_clk) disable iff (!nrst)
      (state_r == ST_OFF) ##1 (state_r == ST_OFF) |-> !gateHighA && !gateHighB && !gateLowA && !gateLowB;
  endproperty
  a_off_quiet : assert property (p_off_quiet) else $error("outputs on during off"); // [RULE3]

  property p_regen;
    @(posedge sys_clk) disable iff (!nrst)
      (overCurrent_r && driving) |=> gateLowA && gateLowB && !gateHighA && !gateHighB;
  endproperty
  a_regen : assert property (p_regen) else $error("no regeneration"); // [RULE7]

  property p_oc_sense;
    @(posedge sys_clk) disable iff (!nrst) $rose(ocSync_r[1]) |=> overCurrent_r;
  endproperty
  a_oc_sense : assert property (p_oc_sense) else $error("limiter late"); // [RULE6]

  property p_recover;
    @(posedge sys_clk) disable iff (!nrst)
      (state_r == ST_RETRY && hallEdge) |=> state_r == ST_RUN && attempts_r == '0;
  endproperty
  a_recover : assert property (p_recover) else $error("no recovery"); // [RULE11]

  property p_tach;
    @(posedge sys_clk) disable iff (!nrst) (!LOCK_OUT && hallEdge) |=> ##1 rotOe != $past(rotOe);
  endproperty
  a_tach : assert property (p_tach) else $error("tach not toggled"); // [RULE8]

  property p_lock_pin;
    @(posedge sys_clk) disable iff (!nrst) (LOCK_OUT && state_r == ST_OFF) |-> rotOe;
  endproperty
  a_lock_pin : assert property (p_lock_pin) else $error("lock pin wrong"); // [RULE9]

  // [RULE10] partial slew step
  property p_gain;
    @(posedge sys_clk) disable iff (!nrst)
      (dutyTarget > duty_r && (dutyTarget - duty_r) > DUTY_W'(SLEW_MIN))
      |=> duty_r > $past(duty_r) && duty_r < $past(dutyTarget);
  endproperty
  a_gain : assert property (p_gain) else $error("duty slew wrong"); // [RULE10]

  c_lock    : cover property (@(posedge sys_clk) disable iff (!nrst) state_r == ST_OFF);
  c_recover : cover property (@(posedge sys_clk) disable iff (!nrst) state_r == ST_RETRY && hallEdge);
  c_long    : cover property (@(posedge sys_clk) disable iff (!nrst) state_r == ST_OFF && longOff);
  c_regen   : cover property (@(posedge sys_clk) disable iff (!nrst) overCurrent_r && driving);
endmodule : blt_lock_ctrl

// [dv/blt_motor_model.sv]
// Purpose: Motor and Hall sensor model
// Assumes: Rotor turns while not stalled
// Notes:   Hall toggles every HALF cycles
`timescale 1ns/100ps
module blt_motor_model
#(
  parameter int HALF = 5000
)
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Load
  input  wire logic stall,
  // Hall level
  output logic      hallIn
);
  int cnt;
  // Release kicks the Hall at once
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      cnt <= 0;
      hallIn <= 1'b0;
    end
    else if (stall)
      cnt <= HALF - 1;
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      hallIn <= ~hallIn;
    end
    else
      cnt <= cnt + 1;
endmodule // blt_motor_model

// [dv/tb_top.sv]
// Purpose: Bench for lock protection and rotation pin
// Assumes: Lock timers shortened
// Notes:   Inputs change on falling edge
`timescale 1ns/100ps
module tb_top
  import blt_pkg::*;
;
  localparam int RL = 6000;
  localparam int SL = 7000;
  localparam int ON = 1000;
  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              stall = 1'b1;
  logic              ocCompIn = 1'b0;
  logic [DUTY_W-1:0] dutyTarget = 11'h7ff;
  logic              hallIn;
  logic [3:0]        gt;
  logic              rotOe;
  logic              lockActive;
  logic              rotOeL;
  logic              rotOd;
  int                bad_count = 0;
  int                comparisons = 0;
  // Diagonal fully on
  wire               drv = (gt[3] & gt[0]) | (gt[1] & gt[2]);
  always #5 sys_clk = ~sys_clk;
  blt_motor_model #(.HALF(5000)) mot_u (.sys_clk(sys_clk), .nrst(nrst), .stall(stall), .hallIn(hallIn));
  blt_lock_ctrl #(.RUN_LOCK(RL), .STRT_LOCK(SL), .ON_TIME(ON)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
    .hallIn(hallIn), .ocCompIn(ocCompIn), .dutyTarget(dutyTarget), .gateHighA(gt[3]), .gateLowA(gt[2]),
    .gateHighB(gt[1]), .gateLowB(gt[0]), .rotOut(rotOd), .rotOe(rotOe), .lockActive(lockActive));
  // Lock pin, low gain variant
  blt_lock_ctrl #(.RUN_LOCK(RL), .STRT_LOCK(SL), .ON_TIME(ON), .LOCK_OUT(1'b1), .LOW_GAIN(1'b1)) dut_lock_u
    (.sys_clk(sys_clk), .nrst(nrst), .hallIn(hallIn), .ocCompIn(ocCompIn), .dutyTarget(dutyTarget),
    .gateHighA(), .gateLowA(), .gateHighB(), .gateLowB(), .rotOut(), .rotOe(rotOeL), .lockActive());
  task automatic complete_run();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    complete_run();
  endtask
  task automatic chkv(string nm, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic chkr(string nm, int lo, int hi, int got);
    comparisons++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("wrong value %s expected %0d to %0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wait_lock(logic v, int lim, output int n);
    for (n = 0; lockActive !== v; n++)
    begin
      if (n == lim)
        give_up();
      @(negedge sys_clk);
    end
  endtask
  task automatic wait_hall();
    logic h;
    int   k;
    h = hallIn;
    for (k = 0; hallIn === h; k++)
    begin
      if (k == 6000)
        give_up();
      @(negedge sys_clk);
    end
  endtask
  task automatic wait_rise(output int n);
    logic p;
    for (n = 1; n < 3000; n++)
    begin
      p = drv;
      @(negedge sys_clk);
      if (p === 1'b0 && drv === 1'b1)
        break;
    end
  endtask
  // Length of a gate-off run
  task automatic off_len(int lo, int hi);
    int n;
    int k;
    n = 0;
    for (k = 0; k < 40000 && !(gt !== 4'h0 && n > 100); k++)
    begin
      @(negedge sys_clk);
      if (gt === 4'h0)
        n++;
      else if (n <= 100)
        n = 0;
    end
    chkr("off time", lo, hi, n);
  endtask
  task automatic t_startup();
    int n;
    wait_lock(1'b1, SL + 50, n);
    chkr("start lock", SL - 5, SL + 10, n);
    repeat (2) @(negedge sys_clk);
    chkv("lock pin", 1'b1, rotOeL);
  endtask
  task automatic t_recover();
    int n;
    stall = 1'b0;
    wait_lock(1'b0, 20, n);
    chkr("recovery", 1, 10, n);
    repeat (2) @(negedge sys_clk);
    chkv("lock pin run", 1'b0, rotOeL);
  endtask
  task automatic t_tach();
    logic r;
    repeat (3)
    begin
      wait_hall();
      r = ~rotOe;
      repeat (8) @(negedge sys_clk);
      chkv("tach pin", r, rotOe);
      chkv("rot data", 1'b0, rotOd);
    end
  endtask
  task automatic t_pwm();
    int n;
    dutyTarget = 11'h100;
    wait_hall();
    repeat (10) @(negedge sys_clk);
    wait_rise(n);
    wait_rise(n);
    chkr("carrier", PWM_PERIOD - 1, PWM_PERIOD + 1, n);
    dutyTarget = 11'h7ff;
  endtask
  task automatic t_overcurrent();
    ocCompIn = 1'b1;
    repeat (6) @(negedge sys_clk);
    repeat (20)
    begin
      chkv("regen", 4'h5, gt);
      @(negedge sys_clk);
    end
    ocCompIn = 1'b0;
  endtask
  task automatic t_runlock();
    int n;
    wait_hall();
    stall = 1'b1;
    wait_lock(1'b1, RL + 50, n);
    chkr("run lock", RL - 5, RL + 10, n);
    repeat (2) @(negedge sys_clk);
    chkv("lock pin", 1'b1, rotOeL);
  endtask
  initial
  begin
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    t_startup();
    repeat (4) off_len(5 * ON - 5, 5 * ON + 45);
    off_len(20 * ON - 5, 20 * ON + 45);
    t_recover();
    t_tach();
    t_pwm();
    t_overcurrent();
    t_runlock();
    off_len(5 * ON - 5, 5 * ON + 45);
    complete_run();
  end
endmodule // tb_top
